// file: include/card_socket_defines.svh
`ifndef CARD_SOCKET_DEFINES_SVH
`define CARD_SOCKET_DEFINES_SVH

// ==========================================================================
// Register map, byte offsets in the socket register space
// ==========================================================================
`define CSR_ADDR_W        12
`define CSR_ID_OFFSET     12'h800
`define CSR_STATUS_OFFSET 12'h801
`define CSR_UNMAPPED_READ 8'h00

// ==========================================================================
// Identification and revision register fields
// ==========================================================================
`define ID_KIND_MSB       7
`define ID_KIND_LSB       6
`define ID_KIND_CODE      2'h2
`define ID_SPARE_MSB      5
`define ID_SPARE_LSB      4
`define ID_REV_MSB        3
`define ID_REV_LSB        0
`define ID_SPARE_RESET    2'h0

// ==========================================================================
// Interface status register fields
// ==========================================================================
`define ST_RSVD_BIT       7
`define ST_POWER_BIT      6
`define ST_READY_BIT      5
`define ST_WP_BIT         4
`define ST_CD2_BIT        3
`define ST_CD1_BIT        2
`define ST_PIN_HI_BIT     1
`define ST_PIN_LO_BIT     0
`define ST_PIN_FIELDS     6

`endif

// file: include/card_socket_pkg.sv
package card_socket_pkg;

	// Kind of card in the socket, selects meaning of the low status bits
	typedef enum logic {
		CARD_MEMORY,
		CARD_IO
	} card_kind_e;

	// Decoded battery condition of a memory card
	typedef enum logic [1:0] {
		BATT_DEAD,
		BATT_LOW,
		BATT_GOOD
	} battery_state_e;

	// Read answer sequencing
	typedef enum logic {
		RD_IDLE,
		RD_ANSWER
	} read_phase_e;

	typedef logic [7:0] csr_byte_t;

endpackage

// file: core/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Two-flop synchroniser for slow card pins
// ==========================================================================
// No reset on purpose: the status bits must track the pins even while the
// controller itself is held in reset.
module pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic [WIDTH-1:0] pin_in,
	output var  logic [WIDTH-1:0] pin_sync_out
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys) begin
		meta_r <= pin_in;
		sync_r <= meta_r;
	end

	assign pin_sync_out = sync_r;

endmodule // pin_sync

`default_nettype wire

// file: core/id_revision_store.sv
`timescale 1ns/1ns
`default_nettype none
`include "card_socket_defines.svh"

// ==========================================================================
// Writable part of the identification register (spare bits and revision)
// ==========================================================================
module id_revision_store #(
	parameter logic [3:0] REV_DEFAULT = 4'h3
) (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       wr_en,
	input  wire logic       wr_permit,
	input  wire logic [5:0] wr_data,
	output var  logic [1:0] spare_bits,
	output var  logic [3:0] revision
);

	// Spare emulation bits: storage only, steer nothing
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			spare_bits <= `ID_SPARE_RESET;
		end else if (wr_en && wr_permit) begin
			spare_bits <= wr_data[5:4];
		end
	end

	// Revision field, reloaded with the newer code on reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			revision <= REV_DEFAULT;
		end else if (wr_en && wr_permit) begin
			revision <= wr_data[3:0];
		end
	end

endmodule // id_revision_store

`default_nettype wire

// file: core/card_socket_id_status_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "card_socket_defines.svh"


module card_socket_id_status_regs
	import card_socket_pkg::*;
#(
	parameter logic [3:0] REV_DEFAULT = 4'h3, // Newer revision code, arbitrary value
	parameter logic [3:0] REV_LEGACY  = 4'h1  // Older revision code, arbitrary value
) (
	input  wire logic                   clk_sys,
	input  wire logic                   sys_rst,
	// Register port in the socket register space
	input  wire logic [`CSR_ADDR_W-1:0] reg_addr,
	input  wire logic                   reg_wr_en,
	input  wire logic                   reg_rd_en,
	input  wire logic [7:0]             reg_wdata,
	output var  logic [7:0]             reg_rdata,
	output var  logic                   reg_rvalid,
	// Controls from neighbouring registers
	input  wire logic                   id_write_permit,
	input  wire logic                   socket_power_on_flag,
	input  wire card_socket_pkg::card_kind_e card_kind,
	// Card pins
	input  wire logic                   card_ready,
	input  wire logic                   card_write_protect_flag,
	input  wire logic                   insert_sense_first_n,
	input  wire logic                   insert_sense_second_n,
	input  wire logic                   battery_detect_first,
	input  wire logic                   battery_detect_second,
	input  wire logic                   card_speaker,
	input  wire logic                   card_status_change,
	// Derived state for the rest of the controller
	output var  logic                   legacy_compat_mode,
	output var  logic                   card_fully_seated,
	output var  card_socket_pkg::battery_state_e battery_state,
	output var  logic                   status_event
);

	import card_socket_pkg::*;

	// ======================================================================
	// Functions
	// ======================================================================

	// Address match, shared by the read and write decoders
	function automatic logic addr_hit(
		input logic [`CSR_ADDR_W-1:0] addr,
		input logic [`CSR_ADDR_W-1:0] offset
	);
		addr_hit = (addr == offset);
	endfunction

	// Battery pins to condition; either pattern with the second pin low is dead
	function automatic battery_state_e battery_decode(
		input logic second_pin,
		input logic first_pin
	);
		if (!second_pin) begin
			battery_decode = BATT_DEAD;
		end else if (!first_pin) begin
			battery_decode = BATT_LOW;
		end else begin
			battery_decode = BATT_GOOD;
		end
	endfunction

	// ======================================================================
	// Pin synchronisation
	// ======================================================================

	localparam int PIN_W = 8;

	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] pins_sync;

	// Pack pins so one synchroniser instance covers them all
	assign pins_raw = {card_status_change,
	                   card_speaker,
	                   battery_detect_first,
	                   battery_detect_second,
	                   insert_sense_first_n,
	                   insert_sense_second_n,
	                   card_write_protect_flag,
	                   card_ready};

	// Slow pins; two flops are ample at this clock rate
	pin_sync #(
		.WIDTH        (PIN_W)
	) u_pin_sync (
		.clk_sys      (clk_sys),
		.pin_in       (pins_raw),
		.pin_sync_out (pins_sync)
	);

	logic ready_s;
	logic wp_s;
	logic cd2_n_s;
	logic cd1_n_s;
	logic bvd2_s;
	logic bvd1_s;
	logic spkr_s;
	logic stschg_s;

	// Unpack synchronised pins
	assign ready_s  = pins_sync[0];
	assign wp_s     = pins_sync[1];
	assign cd2_n_s  = pins_sync[2];
	assign cd1_n_s  = pins_sync[3];
	assign bvd2_s   = pins_sync[4];
	assign bvd1_s   = pins_sync[5];
	assign spkr_s   = pins_sync[6];
	assign stschg_s = pins_sync[7];

	// ======================================================================
	// Write decode
	// ======================================================================

	logic id_wr;

	// Only the identification byte takes writes; status is read-only
	always_comb begin
		if (reg_wr_en && addr_hit(reg_addr, `CSR_ID_OFFSET)) begin
			id_wr = 1'b1;
		end else begin
			id_wr = 1'b0;
		end
	end

	// ======================================================================
	// Identification and revision register
	// ======================================================================

	logic [1:0] id_spare;
	logic [3:0] id_revision;

	// Permit gates the whole write; kind bits are never stored at all
	id_revision_store #(
		.REV_DEFAULT (REV_DEFAULT)
	) u_id_store (
		.clk_sys     (clk_sys),
		.sys_rst     (sys_rst),
		.wr_en       (id_wr),
		.wr_permit   (id_write_permit),
		.wr_data     (reg_wdata[`ID_SPARE_MSB:`ID_REV_LSB]),
		.spare_bits  (id_spare),
		.revision    (id_revision)
	);

	csr_byte_t id_value;

	// Assemble the identification byte
	always_comb begin
		id_value = 8'h00;
		id_value[`ID_KIND_MSB:`ID_KIND_LSB] = `ID_KIND_CODE;
		id_value[`ID_SPARE_MSB:`ID_SPARE_LSB] = id_spare;
		id_value[`ID_REV_MSB:`ID_REV_LSB] = id_revision;
	end

	// Legacy mode follows the stored revision, so a later write of any
	// other code leaves legacy mode again
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			legacy_compat_mode <= 1'b0;
		end else begin
			legacy_compat_mode <= (id_revision == REV_LEGACY);
		end
	end

	// ======================================================================
	// Socket power flag
	// ======================================================================

	logic power_on_r;

	// Held off through reset even if the power logic lags its own reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			power_on_r <= 1'b0;
		end else begin
			power_on_r <= socket_power_on_flag;
		end
	end

	// ======================================================================
	// Interface status register
	// ======================================================================

	logic [1:0] low_pins;
	csr_byte_t  status_value;

	// Low pair means battery pins for memory cards, audio/change for I/O
	always_comb begin
		if (card_kind == CARD_IO) begin
			low_pins = {spkr_s, stschg_s};
		end else begin
			low_pins = {bvd2_s, bvd1_s};
		end
	end

	// Assemble the status byte; pin bits are never reset, only the top pair
	always_comb begin
		status_value = 8'h00;
		status_value[`ST_RSVD_BIT]   = 1'b0;
		status_value[`ST_POWER_BIT]  = power_on_r;
		status_value[`ST_READY_BIT]  = ready_s;
		status_value[`ST_WP_BIT]     = wp_s;
		status_value[`ST_CD2_BIT]    = ~cd2_n_s;
		status_value[`ST_CD1_BIT]    = ~cd1_n_s;
		status_value[`ST_PIN_HI_BIT] = low_pins[1];
		status_value[`ST_PIN_LO_BIT] = low_pins[0];
	end

	// ======================================================================
	// Derived socket state
	// ======================================================================

	// Full seating needs both detect bits set
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			card_fully_seated <= 1'b0;
		end else begin
			card_fully_seated <= status_value[`ST_CD2_BIT] &
			                     status_value[`ST_CD1_BIT];
		end
	end

	// Battery condition is only meaningful for memory cards
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			battery_state <= BATT_DEAD;
		end else if (card_kind == CARD_MEMORY) begin
			battery_state <= battery_decode(bvd2_s, bvd1_s);
		end else begin
			battery_state <= BATT_DEAD;
		end
	end

	// ======================================================================
	// Status change pulse
	// ======================================================================

	logic [`ST_PIN_FIELDS-1:0] pin_field_prev_r;
	logic                      prev_valid_r;

	// Remember last pin view; first cycle after reset only primes it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pin_field_prev_r <= '0;
			prev_valid_r     <= 1'b0;
		end else begin
			pin_field_prev_r <= status_value[`ST_PIN_FIELDS-1:0];
			prev_valid_r     <= 1'b1;
		end
	end

	// One-cycle pulse when any pin-driven status bit moves
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			status_event <= 1'b0;
		end else begin
			status_event <= prev_valid_r &&
			                (pin_field_prev_r != status_value[`ST_PIN_FIELDS-1:0]);
		end
	end

	// ======================================================================
	// Read path
	// ======================================================================

	csr_byte_t read_mux;

	// Read decode; unmapped offsets answer with zero rather than stall
	always_comb begin
		if (addr_hit(reg_addr, `CSR_ID_OFFSET)) begin
			read_mux = id_value;
		end else if (addr_hit(reg_addr, `CSR_STATUS_OFFSET)) begin
			read_mux = status_value;
		end else begin
			read_mux = `CSR_UNMAPPED_READ;
		end
	end

	read_phase_e rd_phase_r;

	// Answer phase: one cycle after each taken read
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rd_phase_r <= RD_IDLE;
		end else begin
			case (rd_phase_r)
				RD_IDLE: begin
					if (reg_rd_en) begin
						rd_phase_r <= RD_ANSWER;
					end
				end
				RD_ANSWER: begin
					if (!reg_rd_en) begin
						rd_phase_r <= RD_IDLE;
					end
				end
				default: begin
					rd_phase_r <= RD_IDLE;
				end
			endcase
		end
	end

	// Valid decoded from the answer phase flop, so it cannot glitch;
	// back-to-back reads hold the phase in answer and keep valid high, one cycle per read
	assign reg_rvalid = (rd_phase_r == RD_ANSWER);

	// Data captured with the read and held until the next read; a write in
	// the same cycle is seen only by the following read
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd_en) begin
			reg_rdata <= read_mux;
		end
	end

endmodule // card_socket_id_status_regs

`default_nettype wire

// file: tb/card_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Card in the socket
// ==========================================
module card_model
	import card_socket_pkg::*;
(
	input  wire card_socket_pkg::card_kind_e kind,
	input  wire logic [1:0]                  ins,
	input  wire logic [1:0]                  lv,
	output wire logic                        cd1_n,
	output wire logic                        cd2_n,
	output wire logic                        bvd1,
	output wire logic                        bvd2,
	output wire logic                        spk,
	output wire logic                        sts
);
	import card_socket_pkg::*;
	// Detect contacts pulled up until made
	assign cd1_n = ~ins[0];
	assign cd2_n = ~ins[1];
	// Unused pin pair shows the inverse, so a wrong select is seen
	assign {bvd2, bvd1} = (kind == CARD_MEMORY) ? lv : ~lv;
	assign {spk, sts}   = (kind == CARD_IO) ? lv : ~lv;
endmodule // card_model

`default_nettype wire

// file: tb/card_socket_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "card_socket_defines.svh"

// ==========================================
// Port checks of the id and status registers
// ==========================================
module card_socket_monitor
	import card_socket_pkg::*;
#(
	parameter logic [3:0] REV_LEGACY = 4'h1
) (
	input  wire logic                        clk_sys,
	input  wire logic                        sys_rst,
	input  wire logic [`CSR_ADDR_W-1:0]      reg_addr,
	input  wire logic                        reg_wr_en,
	input  wire logic                        reg_rd_en,
	input  wire logic [7:0]                  reg_wdata,
	input  wire logic [7:0]                  reg_rdata,
	input  wire logic                        reg_rvalid,
	input  wire logic                        id_write_permit,
	input  wire logic                        socket_power_on_flag,
	input  wire card_socket_pkg::card_kind_e card_kind,
	input  wire logic                        card_ready,
	input  wire logic                        card_write_protect_flag,
	input  wire logic                        insert_sense_first_n,
	input  wire logic                        insert_sense_second_n,
	input  wire logic                        battery_detect_first,
	input  wire logic                        battery_detect_second,
	input  wire logic                        card_speaker,
	input  wire logic                        card_status_change,
	input  wire logic                        legacy_compat_mode,
	input  wire logic                        status_event
);
	import card_socket_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Read strobes by target and expected pin image
	wire logic rd_id = reg_rd_en && reg_addr == `CSR_ID_OFFSET;
	wire logic rd_st = reg_rd_en && reg_addr == `CSR_STATUS_OFFSET;
	wire logic rd_un = reg_rd_en && !rd_id && !rd_st;
	wire logic [5:0] st_exp = {card_ready, card_write_protect_flag, !insert_sense_second_n,
		!insert_sense_first_n, (card_kind == CARD_IO) ? {card_speaker, card_status_change} :
		{battery_detect_second, battery_detect_first}};
	// Pins quiet long enough to cross the synchroniser
	sequence s_quiet;
		$stable(st_exp)[*4];
	endsequence
	sequence s_rd_st_quiet;
		s_quiet ##0 rd_st;
	endsequence

	AST_RVALID_LAT: assert property (reg_rd_en |=> reg_rvalid)
		else $error("read answer missing");
	AST_RVALID_ONLY: assert property (!reg_rd_en |=> !reg_rvalid)
		else $error("answer without read");
	AST_ID_KIND: assert property (rd_id |=> reg_rdata[7:6] == 2'h2)
		else $error("interface kind code wrong");
	AST_ST_RSVD: assert property (rd_st |=> !reg_rdata[7])
		else $error("status bit 7 set");
	AST_ST_POWER: assert property (rd_st && !$past(sys_rst) |=>
		reg_rdata[6] == $past(socket_power_on_flag, 2))
		else $error("power bit wrong");
	AST_ST_PINS: assert property (s_rd_st_quiet |=>
		reg_rdata[5:2] == $past(st_exp[5:2]))
		else $error("ready, protect or detect bit wrong");
	AST_ST_LOW: assert property (s_rd_st_quiet |=> reg_rdata[1:0] == $past(st_exp[1:0]))
		else $error("low status pair wrong");
	AST_UNMAPPED: assert property (rd_un |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_LEGACY: assert property (reg_wr_en && reg_addr == `CSR_ID_OFFSET && id_write_permit
		&& reg_wdata[3:0] == REV_LEGACY |-> ##2 legacy_compat_mode)
		else $error("legacy mode not entered");
	AST_EVENT: assert property ($changed(st_exp[5:2]) |-> ##3 status_event)
		else $error("status change pulse missing");
endmodule // card_socket_monitor

bind card_socket_id_status_regs card_socket_monitor #(.REV_LEGACY(REV_LEGACY)) mon (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
	.reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .id_write_permit(id_write_permit),
	.socket_power_on_flag(socket_power_on_flag), .card_kind(card_kind),
	.card_ready(card_ready), .card_write_protect_flag(card_write_protect_flag),
	.insert_sense_first_n(insert_sense_first_n), .insert_sense_second_n(insert_sense_second_n),
	.battery_detect_first(battery_detect_first), .battery_detect_second(battery_detect_second),
	.card_speaker(card_speaker), .card_status_change(card_status_change),
	.legacy_compat_mode(legacy_compat_mode), .status_event(status_event));

`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "card_socket_defines.svh"

// ==========================================
// Register bench
// ==========================================
module tb;
	import card_socket_pkg::*;
	localparam logic [3:0] REV_D = 4'h3; // Arbitrary revision codes
	localparam logic [3:0] REV_L = 4'h1;
	localparam logic [11:0] ID = `CSR_ID_OFFSET;
	localparam logic [11:0] ST = `CSR_STATUS_OFFSET;
	logic clk_sys = 0, sys_rst = 1, wr = 0, rd = 0, power = 0, permit = 0, rdy = 1, wp = 0;
	logic [11:0] addr = 0;
	logic [7:0] wdata = 0;
	logic [1:0] ins = 2'h3, lv = 2'h2;
	card_kind_e kind = CARD_MEMORY;
	wire logic [7:0] rdata;
	wire logic rvalid, legacy, seated, evt, cd1_n, cd2_n, bvd1, bvd2, spk, sts;
	battery_state_e bstate;
	int err_total = 0, total_checks = 0;

	always #2 clk_sys = ~clk_sys;

	card_model card (.kind(kind), .ins(ins), .lv(lv), .cd1_n(cd1_n), .cd2_n(cd2_n),
		.bvd1(bvd1), .bvd2(bvd2), .spk(spk), .sts(sts));
	card_socket_id_status_regs #(.REV_DEFAULT(REV_D), .REV_LEGACY(REV_L)) dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(addr), .reg_wr_en(wr),
		.reg_rd_en(rd), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.id_write_permit(permit), .socket_power_on_flag(power), .card_kind(kind),
		.card_ready(rdy), .card_write_protect_flag(wp), .insert_sense_first_n(cd1_n),
		.insert_sense_second_n(cd2_n), .battery_detect_first(bvd1),
		.battery_detect_second(bvd2), .card_speaker(spk), .card_status_change(sts),
		.legacy_compat_mode(legacy), .card_fully_seated(seated), .battery_state(bstate),
		.status_event(evt));

	// Compare and count
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	// One-cycle strobes, launched just after the edge
	task wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1 wr = 1;
		addr = a;
		wdata = d;
		@(posedge clk_sys);
		#1 wr = 0;
	endtask
	task rd_chk(input logic [11:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		#1 rd = 1;
		addr = a;
		@(posedge clk_sys);
		#1 rd = 0;
		chk({7'h0, rvalid}, 8'h01);
		chk(rdata, exp);
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog, well beyond the roughly 150 cycles the tests need
	initial begin
		#20000;
		err_total++;
		report_and_stop();
	end

	// Test sequence
	initial begin
		repeat (8) @(posedge clk_sys);
		#1 sys_rst = 0;
		rd_chk(ID, {4'h8, REV_D});
		rd_chk(ST, 8'h2E);
		$display("test reset_values done");
		wr_reg(ID, 8'hFF);
		rd_chk(ID, {4'h8, REV_D});
		permit = 1;
		wr_reg(ID, 8'hFF);
		rd_chk(ID, 8'hBF);
		wr_reg(ID, 8'h1A);
		rd_chk(ID, 8'h9A);
		wr_reg(ID, {4'h2, REV_L});
		rd_chk(ID, {4'hA, REV_L});
		chk({7'h0, legacy}, 8'h01);
		wr_reg(ID, {4'h0, REV_D});
		rd_chk(ID, {4'h8, REV_D});
		chk({7'h0, legacy}, 8'h00);
		wr_reg(ST, 8'hFF);
		rd_chk(ST, 8'h2E);
		rd_chk(12'h802, 8'h00);
		$display("test id_writes done");
		// Sixteen pin patterns, eight under each card kind
		for (int i = 0; i < 16; i++) begin
			kind = card_kind_e'(i[0]);
			lv = i[2:1];
			ins = i[3:2];
			rdy = i[3] ^ i[0];
			wp = i[1] ^ i[3];
			power = i[2] ^ i[0];
			repeat (4) @(posedge clk_sys);
			#1 rd_chk(ST, {1'b0, power, rdy, wp, ins, lv});
			chk({7'h0, seated}, {7'h0, &ins});
			chk(8'(bstate), 8'(kind == CARD_IO || !lv[1] ? BATT_DEAD :
				lv[0] ? BATT_GOOD : BATT_LOW));
		end
		$display("test status_pins done");
		// Pin change seen only after the synchroniser
		rdy = ~rdy;
		rd_chk(ST, {1'b0, power, ~rdy, wp, ins, lv});
		@(posedge clk_sys);
		#1 chk({7'h0, evt}, 8'h01);
		@(posedge clk_sys);
		#1 chk({7'h0, evt}, 8'h00);
		power = 0;
		wr_reg(ID, {4'h3, REV_L});
		sys_rst = 1;
		ins = 2'h1;
		repeat (3) @(posedge clk_sys);
		#1 sys_rst = 0;
		rd_chk(ID, {4'h8, REV_D});
		chk({7'h0, legacy}, 8'h00);
		rd_chk(ST, {2'h0, rdy, wp, 2'h1, lv});
		$display("test mid_reset done");
		report_and_stop();
	end
endmodule // tb

`default_nettype wire
